// *** design/bridge_config_command_regs.sv ***
// bridge configuration header: identifiers, command register, parity status flag
// assumes requests come from core-clock logic: one-cycle read or write strobes
//
// Overview of operation
// - present this header layout while in transparent mode
// - six access types; sticky keeps value, writing one clears clearable fields
// - offset 00h bits 15:0 read a fixed maker code
// - offset 00h bits 31:16 read a fixed part code
// - io space enable gates primary io response; resets to zero
// - memory space enable gates primary memory reads; resets to zero
// - bus master enable gates upstream mastering and secondary response
// - special cycle enable reads zero, read-only
// - memory write invalidate enable reads zero; pass-through still allowed
// - palette snoop, wait cycle, fast back-to-back read zero
// - parity response enable allows master parity flag; normal handling continues
// - bit 8 enables fatal and non-fatal error messages upstream
// - bit 10 keeps the legacy interrupt deasserted when set
// - bit 24 sets only on poisoned completion or poisoned write, if enabled
module bridge_config_command_regs #(
	parameter logic [15:0] maker_code = 16'h0A5A, // arbitrary value
	parameter logic [15:0] part_code = 16'h0B6B // arbitrary value
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic clock_enable,
	input wire logic transparent_mode,
	input wire cfg_regs_pkg::cfg_request_t request,
	input wire cfg_regs_pkg::error_events_t events,
	input wire logic interrupt_request,
	input wire logic error_pending,
	output logic [31:0] read_data,
	output logic read_valid,
	output cfg_regs_pkg::command_view_t command,
	output logic interrupt_out,
	output logic error_message,
	output logic master_parity_error
);

	// ==========================================================
	// state
	typedef struct packed
	{
		logic [15:0] cmd;
		logic mdpe;
		logic [31:0] rdata;
		logic rvalid;
		cfg_regs_pkg::command_view_t view;
		logic intr;
		logic err_msg;
	} state_t;

	state_t cur;
	state_t next_cur;

	// ==========================================================
	// next state
	always_comb
	begin
		logic wr_cmd;
		logic wr_stat;
		logic [15:0] wmask;
		logic set_mdpe;
		wr_cmd = 1'b0;
		wr_stat = 1'b0;
		wmask = 16'h0000;
		set_mdpe = 1'b0;
		next_cur = cur;
		wr_cmd = request.write && transparent_mode
			&& request.offset == cfg_regs_pkg::command_offset;
		wr_stat = wr_cmd && request.byte_enable[3];
		wmask = cfg_regs_pkg::command_write_mask
			& {{8{request.byte_enable[1]}}, {8{request.byte_enable[0]}}};
		// fixed-zero and reserved bits never enter the mask
		if (wr_cmd)
		begin
			next_cur.cmd = (cur.cmd & ~wmask) | (request.data[15:0] & wmask);
		end
		set_mdpe = cur.cmd[cfg_regs_pkg::parity_response_bit]
			&& (events.poisoned_completion || events.poisoned_write);
		// a set in the same cycle as a clear wins
		next_cur.mdpe = cfg_regs_pkg::field_update(cfg_regs_pkg::write_one_to_clear, cur.mdpe,
			wr_stat, request.data[cfg_regs_pkg::master_parity_bit], set_mdpe);
		next_cur.rvalid = request.read;
		next_cur.rdata = 32'h0000_0000;
		if (request.read && transparent_mode)
		begin
			case (request.offset)
				cfg_regs_pkg::ident_offset: next_cur.rdata = {part_code, maker_code};
				cfg_regs_pkg::command_offset:
					next_cur.rdata = {7'h00, cur.mdpe, 8'h00, 5'h00, cur.cmd[10:0]};
				default: next_cur.rdata = 32'h0000_0000;
			endcase
		end
		next_cur.view.io_space = cur.cmd[cfg_regs_pkg::io_enable_bit];
		next_cur.view.mem_space = cur.cmd[cfg_regs_pkg::mem_enable_bit];
		next_cur.view.bus_master = cur.cmd[cfg_regs_pkg::master_enable_bit];
		next_cur.view.parity_response = cur.cmd[cfg_regs_pkg::parity_response_bit];
		next_cur.view.error_report_enable = cur.cmd[cfg_regs_pkg::error_report_enable_bit];
		next_cur.view.interrupt_disable = cur.cmd[cfg_regs_pkg::interrupt_disable_bit];
		next_cur.intr = interrupt_request && !cur.cmd[cfg_regs_pkg::interrupt_disable_bit];
		next_cur.err_msg = error_pending
			&& cur.cmd[cfg_regs_pkg::error_report_enable_bit];
	end

	// ==========================================================
	// registers; clock_enable freezes everything
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cur <= '0;
			cur.cmd <= cfg_regs_pkg::command_reset;
		end
		else if (clock_enable)
		begin
			cur <= next_cur;
		end
	end

	assign read_data = cur.rdata;
	assign read_valid = cur.rvalid;
	assign command = cur.view;
	assign interrupt_out = cur.intr;
	assign error_message = cur.err_msg;
	assign master_parity_error = cur.mdpe;

endmodule : bridge_config_command_regs

// *** shared/cfg_regs_pkg.sv ***
// configuration header constants, access types and carriers for the bridge header block
// assumes a single core clock and one configuration access port from the primary side
package cfg_regs_pkg;

	// ==========================================================
	// offsets
	localparam logic [11:0] ident_offset = 12'h000;
	localparam logic [11:0] command_offset = 12'h004;
	localparam logic [11:0] status_offset = 12'h004;

	// ==========================================================
	// command field positions
	localparam int io_enable_bit = 0;
	localparam int mem_enable_bit = 1;
	localparam int master_enable_bit = 2;
	localparam int special_cycle_bit = 3;
	localparam int mwi_enable_bit = 4;
	localparam int palette_snoop_bit = 5;
	localparam int parity_response_bit = 6;
	localparam int wait_cycle_bit = 7;
	localparam int error_report_enable_bit = 8;
	localparam int fast_b2b_bit = 9;
	localparam int interrupt_disable_bit = 10;
	localparam int master_parity_bit = 24;

	// writable command bits: 0,1,2,6,8,10
	localparam logic [15:0] command_write_mask = 16'h0547;
	localparam logic [15:0] command_reset = 16'h0000;

	// ==========================================================
	// field access types
	typedef enum logic [2:0]
	{
		read_only = 3'b000,
		read_only_sticky = 3'b001,
		read_write = 3'b010,
		write_one_to_clear = 3'b011,
		read_write_sticky = 3'b100,
		write_one_to_clear_sticky = 3'b101
	} access_t;

	// ==========================================================
	// carriers
	typedef struct packed
	{
		logic read;
		logic write;
		logic [11:0] offset;
		logic [3:0] byte_enable;
		logic [31:0] data;
	} cfg_request_t;

	typedef struct packed
	{
		logic io_space;
		logic mem_space;
		logic bus_master;
		logic parity_response;
		logic error_report_enable;
		logic interrupt_disable;
	} command_view_t;

	typedef struct packed
	{
		logic poisoned_completion;
		logic poisoned_write;
		logic parity_detected;
	} error_events_t;

	// applies one field update by access type
	function automatic logic field_update(input access_t kind, input logic cur,
		input logic wr, input logic wdata, input logic set);
		logic res;
		res = cur;
		case (kind)
			read_write, read_write_sticky: res = wr ? wdata : cur;
			write_one_to_clear, write_one_to_clear_sticky: res = (cur & ~(wr & wdata)) | set;
			read_only_sticky: res = cur | set;
			default: res = cur;
		endcase
		return res;
	endfunction : field_update

endpackage : cfg_regs_pkg

// *** testbench/bridge_checker.sv ***
// assertion checker for the bridge header block
// assumes it is bound onto the design top, one clock
module bridge_checker (
	input wire logic clock,
	input wire logic rstn,
	input wire logic clock_enable,
	input wire logic transparent_mode,
	input wire cfg_regs_pkg::cfg_request_t request,
	input wire cfg_regs_pkg::error_events_t events,
	input wire logic interrupt_request,
	input wire logic error_pending,
	input wire logic [31:0] read_data,
	input wire logic read_valid,
	input wire cfg_regs_pkg::command_view_t command,
	input wire logic interrupt_out,
	input wire logic error_message,
	input wire logic master_parity_error
);
	// ========
	// properties
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire logic rd = clock_enable && transparent_mode && request.read;
	wire logic rc = rd && request.offset == cfg_regs_pkg::command_offset;
	wire logic pz = events.poisoned_completion || events.poisoned_write;
	AST_RV: assert property (rd |=> read_valid)
		else $error("read lost");
	AST_NRV: assert property (clock_enable && !request.read |=> !read_valid)
		else $error("stray read");
	AST_RO: assert property (rc |=>
		(read_data[15:0] & 16'hFAB8) == 16'h0000) else $error("fixed bits set");
	AST_CMD: assert property (rc |=>
		read_data[2:0] == {command.bus_master, command.mem_space, command.io_space}
		&& read_data[24] == $past(master_parity_error)) else $error("command view");
	AST_INT: assert property (clock_enable |=>
		interrupt_out == ($past(interrupt_request) && !command.interrupt_disable))
		else $error("interrupt gate");
	AST_ERR: assert property (clock_enable |=>
		error_message == ($past(error_pending) && command.error_report_enable))
		else $error("error gate");
	AST_MPS: assert property ($rose(master_parity_error) |->
		$past(pz) && command.parity_response) else $error("parity flag cause");
	AST_MPE: assert property (clock_enable && pz |=>
		!command.parity_response || master_parity_error) else $error("parity flag");
endmodule : bridge_checker
bind bridge_config_command_regs bridge_checker checker_inst (.clock(clock), .rstn(rstn),
	.clock_enable(clock_enable), .transparent_mode(transparent_mode), .request(request),
	.events(events), .interrupt_request(interrupt_request), .error_pending(error_pending),
	.read_data(read_data), .read_valid(read_valid), .command(command),
	.interrupt_out(interrupt_out), .error_message(error_message),
	.master_parity_error(master_parity_error));

// *** testbench/root_model.sv ***
// root complex model issuing configuration requests
// assumes requests change at the falling edge
module root_model (
	input wire logic clock,
	output cfg_regs_pkg::cfg_request_t request
);
	timeunit 1ns;
	timeprecision 1ns;
	initial request = '0;
	// ========
	// one-cycle strobe; released data shows the inverse, not a stale copy
	task automatic access(input logic wr, input logic [11:0] off, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clock);
		request <= '{read: !wr, write: wr, offset: off, byte_enable: be, data: d};
		@(negedge clock);
		request <= '{read: 1'b0, write: 1'b0, offset: off, byte_enable: be, data: ~d};
	endtask : access
endmodule : root_model

// *** testbench/tb_top.sv ***
// self-checking bench for the bridge header block
// assumes the root model drives requests, side inputs change at falling edge
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0;
	logic rstn = 0;
	logic irq = 0;
	logic errp = 0;
	logic ce = 1;
	logic tm = 1;
	cfg_regs_pkg::error_events_t ev = '0;
	cfg_regs_pkg::cfg_request_t request;
	cfg_regs_pkg::command_view_t command;
	logic [31:0] rdata;
	logic rvalid, iout, emsg, mpe;
	int bad_count = 0;
	int num_checks = 0;
	always #25 clock = ~clock;
	root_model root_model_inst (.clock(clock), .request(request));
	bridge_config_command_regs bridge_config_command_regs_inst (.clock(clock), .rstn(rstn),
		.clock_enable(ce), .transparent_mode(tm), .request(request), .events(ev),
		.interrupt_request(irq), .error_pending(errp), .read_data(rdata), .read_valid(rvalid),
		.command(command), .interrupt_out(iout), .error_message(emsg),
		.master_parity_error(mpe));
	// ========
	// checks
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : compare
	task automatic rd(input logic [11:0] off, input logic [31:0] exp);
		root_model_inst.access(1'b0, off, 4'hF, 32'h0000_0000);
		compare({rvalid, rdata}, {1'b1, exp});
	endtask : rd
	task automatic wr(input logic [3:0] be, input logic [31:0] d);
		root_model_inst.access(1'b1, cfg_regs_pkg::command_offset, be, d);
	endtask : wr
	// gating by mode and clock enable, then all enable outputs in one compare
	task automatic gates_scenario;
		tm = 1'b0;
		wr(4'h3, 32'h0000_0000);
		rd(cfg_regs_pkg::command_offset, 32'h0000_0000);
		tm = 1'b1;
		rd(cfg_regs_pkg::command_offset, 32'h0000_0147);
		ce = 1'b0;
		wr(4'h3, 32'h0000_0000);
		ce = 1'b1;
		rd(cfg_regs_pkg::command_offset, 32'h0000_0147);
		wr(4'h3, 32'h0000_0007);
		@(negedge clock);
		compare({iout, emsg, command}, {2'b10, 6'h38});
	endtask : gates_scenario
	// parity flag stays clear while response is off; a set beats a same-cycle clear
	task automatic parity_scenario;
		ev.poisoned_write = 1'b1;
		@(negedge clock);
		ev = '0;
		rd(cfg_regs_pkg::command_offset, 32'h0000_0007);
		wr(4'h3, 32'h0000_0047);
		fork
			wr(4'h8, 32'h0100_0000);
			begin
				@(negedge clock);
				ev.poisoned_write = 1'b1;
				@(negedge clock);
				ev = '0;
			end
		join
		rd(cfg_regs_pkg::command_offset, 32'h0100_0047);
	endtask : parity_scenario
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// ========
	// scenarios
	initial
	begin
		repeat (6) @(negedge clock);
		rstn = 1;
		rd(cfg_regs_pkg::ident_offset, 32'h0B6B_0A5A);
		rd(cfg_regs_pkg::command_offset, 32'h0000_0000);
		rd(12'h0FC, 32'h0000_0000);
		wr(4'h3, 32'h0000_FFFF);
		rd(cfg_regs_pkg::command_offset, 32'h0000_0547);
		irq = 1;
		errp = 1;
		@(negedge clock);
		compare({iout, emsg, command}, {2'b01, 6'h3F});
		wr(4'h3, 32'h0000_0147);
		@(negedge clock);
		compare({31'h0, iout}, 32'h1);
		ev.parity_detected = 1'b1;
		@(negedge clock);
		compare({31'h0, mpe}, 32'h0);
		ev = '{poisoned_completion: 1'b1, default: 1'b0};
		@(negedge clock);
		ev = '0;
		rd(cfg_regs_pkg::command_offset, 32'h0100_0147);
		wr(4'h8, 32'h0100_0000);
		rd(cfg_regs_pkg::command_offset, 32'h0000_0147);
		gates_scenario();
		parity_scenario();
		tally_and_finish();
	end
endmodule : tb_top
